// *** rtl/gpx_expander.sv ***
// Overview of operation
// - detect start: data falls while clock is high
// - acknowledge matching address low through ninth clock high phase
// - one bit per clock pulse; data stable while clock high
// - detect stop: data rises while clock high, return to idle
// - each byte is eight bits plus acknowledge; any byte count
// - transmitter releases data before ack; acknowledger holds it low
// - acknowledge every received byte; master acknowledges read bytes
// - on master nack release data so master can stop
// - answer only address 010000 plus address select level
// - direction bit one means read, zero means write
// - first written byte is the command, stored as pointer
// - pointer stays within its register pair until a new command
// - commands 0 to 7 select input, output, invert, direction pairs
// - input registers show pin levels, writes ignored
// - output latches drive output pins, read back latch, reset ones
// - invert bit flips reported input level, resets to zero
// - direction one is input, zero drives; reset all inputs
// - power-on reset holds everything at defaults
// - after each data byte pointer flips to pair partner
// - input pin edges raise interrupt, output pins never do
// - interrupt clears on pin return or input port read ack
// - low reset pin returns registers and bus logic to defaults
`timescale 1ns/100ps
`include "gpx_cfg.svh"

module gpx_expander (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic linkClk,
    input wire logic resetN,
    input wire logic addrSel,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    input wire logic [7:0] port0In,
    input wire logic [7:0] port1In,
    output logic [7:0] port0Out,
    output logic [7:0] port1Out,
    output logic [7:0] port0OeN,
    output logic [7:0] port1OeN,
    output logic intOut,
    output logic intOeN
);

    logic rstAll;
    assign rstAll = reset | ~resetN;

    function automatic logic isInputReg(input logic [2:0] idx);
        isInputReg = (idx[2:1] == 2'(`GPX_REG_IN0 >> 1));
    endfunction : isInputReg

    // link domain: bus sampling
    logic sclM, sclS, sclD, sdaM, sdaS, sdaD, adrM, adrS;
    logic ackM, ackS, ackD;
    logic ackTog;
    always_ff @(posedge linkClk or posedge rstAll) begin
        if (rstAll) begin
            sclM <= 1'b1;
            sclS <= 1'b1;
            sclD <= 1'b1;
            sdaM <= 1'b1;
            sdaS <= 1'b1;
            sdaD <= 1'b1;
            adrM <= 1'b0;
            adrS <= 1'b0;
            ackM <= 1'b0;
            ackS <= 1'b0;
            ackD <= 1'b0;
        end else begin
            sclM <= sclIn;
            sclS <= sclM;
            sclD <= sclS;
            sdaM <= sdaIn;
            sdaS <= sdaM;
            sdaD <= sdaS;
            adrM <= addrSel;
            adrS <= adrM;
            ackM <= ackTog;
            ackS <= ackM;
            ackD <= ackS;
        end
    end

    logic sclRise, sclFall, startSeen, stopSeen, ackEvent, addrHit;
    assign sclRise = sclS & ~sclD;
    assign sclFall = ~sclS & sclD;
    assign startSeen = sclS & sclD & sdaD & ~sdaS;
    assign stopSeen = sclS & sclD & ~sdaD & sdaS;
    assign ackEvent = ackS ^ ackD;

    gpx_pkg::gpx_state_t state, next_state;
    logic [3:0] bitCnt, next_bitCnt;
    logic [7:0] shift, next_shift;
    logic [7:0] rdHold, next_rdHold;
    logic [7:0] reqData, next_reqData;
    logic [2:0] ptr, next_ptr, reqIdx, next_reqIdx;
    logic rw, next_rw, gotCmd, next_gotCmd, acked, next_acked;
    logic next_sdaOeN, reqTog, next_reqTog, reqWr, next_reqWr;
    logic reqClr, next_reqClr, reqClrPort, next_reqClrPort;
    logic [7:0] sysRdata;

    assign addrHit = (shift[7:1] == {`GPX_ADDR_FIXED, adrS});

    always_comb begin
        next_state = state;
        next_bitCnt = bitCnt;
        next_shift = shift;
        next_rdHold = ackEvent ? sysRdata : rdHold;
        next_ptr = ptr;
        next_rw = rw;
        next_gotCmd = gotCmd;
        next_acked = acked;
        next_sdaOeN = sdaOeN;
        next_reqTog = reqTog;
        next_reqWr = reqWr;
        next_reqIdx = reqIdx;
        next_reqData = reqData;
        next_reqClr = reqClr;
        next_reqClrPort = reqClrPort;
        if (stopSeen) begin
            next_state = gpx_pkg::GPX_IDLE;
            next_sdaOeN = 1'b1;
        end else if (startSeen) begin
            next_state = gpx_pkg::GPX_ADDR;
            next_bitCnt = 4'h0;
            next_sdaOeN = 1'b1;
        end else begin
            case (state)
                gpx_pkg::GPX_ADDR: begin
                    if (sclRise) begin
                        next_shift = {shift[6:0], sdaS};
                        next_bitCnt = bitCnt + 4'h1;
                    end else if (sclFall && bitCnt == `GPX_BITS) begin
                        if (addrHit) begin
                            next_sdaOeN = 1'b0;
                            next_state = gpx_pkg::GPX_ADDR_ACK;
                            next_rw = shift[0];
                            if (shift[0]) begin
                                next_reqTog = ~reqTog;
                                next_reqWr = 1'b0;
                                next_reqIdx = ptr;
                                next_reqClr = 1'b0;
                            end
                        end else begin
                            next_state = gpx_pkg::GPX_IDLE;
                        end
                    end
                end
                gpx_pkg::GPX_ADDR_ACK: begin
                    if (sclFall) begin
                        next_bitCnt = 4'h0;
                        if (rw) begin
                            next_state = gpx_pkg::GPX_TX;
                            next_shift = rdHold;
                            next_sdaOeN = rdHold[7];
                        end else begin
                            next_state = gpx_pkg::GPX_RX;
                            next_sdaOeN = 1'b1;
                            next_gotCmd = 1'b0;
                        end
                    end
                end
                gpx_pkg::GPX_RX: begin
                    if (sclRise) begin
                        next_shift = {shift[6:0], sdaS};
                        next_bitCnt = bitCnt + 4'h1;
                    end else if (sclFall && bitCnt == `GPX_BITS) begin
                        next_sdaOeN = 1'b0;
                        next_state = gpx_pkg::GPX_RX_ACK;
                        if (!gotCmd) begin
                            next_ptr = shift[2:0];
                            next_gotCmd = 1'b1;
                        end else begin
                            next_reqTog = ~reqTog;
                            next_reqWr = 1'b1;
                            next_reqIdx = ptr;
                            next_reqData = shift;
                            next_reqClr = 1'b0;
                            next_ptr = {ptr[2:1], ~ptr[0]};
                        end
                    end
                end
                gpx_pkg::GPX_RX_ACK: begin
                    // hold ack through the high phase
                    if (sclFall) begin
                        next_sdaOeN = 1'b1;
                        next_bitCnt = 4'h0;
                        next_state = gpx_pkg::GPX_RX;
                    end
                end
                gpx_pkg::GPX_TX: begin
                    // change data only while clock low
                    if (sclRise) begin
                        next_bitCnt = bitCnt + 4'h1;
                    end else if (sclFall) begin
                        if (bitCnt == `GPX_BITS) begin
                            next_sdaOeN = 1'b1;
                            next_state = gpx_pkg::GPX_TX_ACK;
                        end else begin
                            next_shift = {shift[6:0], 1'b0};
                            next_sdaOeN = shift[6];
                        end
                    end
                end
                gpx_pkg::GPX_TX_ACK: begin
                    if (sclRise) begin
                        next_acked = ~sdaS;
                        next_ptr = {ptr[2:1], ~ptr[0]};
                        next_reqTog = ~reqTog;
                        next_reqWr = 1'b0;
                        next_reqIdx = {ptr[2:1], ~ptr[0]};
                        next_reqClr = isInputReg(ptr);
                        next_reqClrPort = ptr[0];
                    end else if (sclFall) begin
                        if (acked) begin
                            next_state = gpx_pkg::GPX_TX;
                            next_bitCnt = 4'h0;
                            next_shift = rdHold;
                            next_sdaOeN = rdHold[7];
                        end else begin
                            next_state = gpx_pkg::GPX_IDLE;
                            next_sdaOeN = 1'b1;
                        end
                    end
                end
                default: begin
                    next_state = gpx_pkg::GPX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge linkClk or posedge rstAll) begin
        if (rstAll) begin
            state <= gpx_pkg::GPX_IDLE;
            bitCnt <= 4'h0;
            shift <= 8'h00;
            rdHold <= 8'h00;
            ptr <= `GPX_PTR_RST;
            rw <= 1'b0;
            gotCmd <= 1'b0;
            acked <= 1'b0;
            sdaOeN <= 1'b1;
            sdaOut <= 1'b0;
            reqTog <= 1'b0;
            reqWr <= 1'b0;
            reqIdx <= `GPX_PTR_RST;
            reqData <= 8'h00;
            reqClr <= 1'b0;
            reqClrPort <= 1'b0;
        end else begin
            state <= next_state;
            bitCnt <= next_bitCnt;
            shift <= next_shift;
            rdHold <= next_rdHold;
            ptr <= next_ptr;
            rw <= next_rw;
            gotCmd <= next_gotCmd;
            acked <= next_acked;
            sdaOeN <= next_sdaOeN;
            sdaOut <= 1'b0;
            reqTog <= next_reqTog;
            reqWr <= next_reqWr;
            reqIdx <= next_reqIdx;
            reqData <= next_reqData;
            reqClr <= next_reqClr;
            reqClrPort <= next_reqClrPort;
        end
    end

    // sys domain; request payload is held steady until the ack toggles
    logic rqM, rqS, rqD, reqEvent;
    logic [15:0] pinM, pinS;
    always_ff @(posedge clk_sys or posedge rstAll) begin
        if (rstAll) begin
            rqM <= 1'b0;
            rqS <= 1'b0;
            rqD <= 1'b0;
            pinM <= 16'h0000;
            pinS <= 16'h0000;
        end else begin
            rqM <= reqTog;
            rqS <= rqM;
            rqD <= rqS;
            pinM <= {port1In, port0In};
            pinS <= pinM;
        end
    end
    assign reqEvent = rqS ^ rqD;

    logic [7:0] inv0, inv1, next_inv0, next_inv1;
    logic [7:0] next_port0Out, next_port1Out;
    logic [7:0] next_port0OeN, next_port1OeN, next_sysRdata;
    logic [15:0] snap, next_snap, level;
    logic [1:0] initCnt, next_initCnt;
    logic next_ackTog, next_intOeN, pending;

    assign level = pinS ^ {inv1, inv0};
    assign pending = (initCnt == `GPX_INIT_WAIT)
        && |((pinS ^ snap) & {port1OeN, port0OeN});

    always_comb begin
        next_port0Out = port0Out;
        next_port1Out = port1Out;
        next_inv0 = inv0;
        next_inv1 = inv1;
        next_port0OeN = port0OeN;
        next_port1OeN = port1OeN;
        next_sysRdata = sysRdata;
        next_ackTog = ackTog;
        next_snap = snap;
        next_initCnt = initCnt;
        // snapshot follows the pins until the sync chain has settled
        if (initCnt != `GPX_INIT_WAIT) begin
            next_initCnt = initCnt + 2'h1;
            next_snap = pinS;
        end
        if (reqEvent) begin
            next_ackTog = ~ackTog;
            if (reqWr) begin
                case (reqIdx)
                    `GPX_REG_OUT0: next_port0Out = reqData;
                    `GPX_REG_OUT1: next_port1Out = reqData;
                    `GPX_REG_INV0: next_inv0 = reqData;
                    `GPX_REG_INV1: next_inv1 = reqData;
                    `GPX_REG_DIR0: next_port0OeN = reqData;
                    `GPX_REG_DIR1: next_port1OeN = reqData;
                    default: next_sysRdata = sysRdata;
                endcase
            end else begin
                case (reqIdx)
                    `GPX_REG_IN0: next_sysRdata = level[7:0];
                    `GPX_REG_IN1: next_sysRdata = level[15:8];
                    `GPX_REG_OUT0: next_sysRdata = port0Out;
                    `GPX_REG_OUT1: next_sysRdata = port1Out;
                    `GPX_REG_INV0: next_sysRdata = inv0;
                    `GPX_REG_INV1: next_sysRdata = inv1;
                    `GPX_REG_DIR0: next_sysRdata = port0OeN;
                    default: next_sysRdata = port1OeN;
                endcase
            end
            if (reqClr && !reqClrPort) begin
                next_snap[7:0] = pinS[7:0];
            end
            if (reqClr && reqClrPort) begin
                next_snap[15:8] = pinS[15:8];
            end
        end
        next_intOeN = ~pending;
    end

    always_ff @(posedge clk_sys or posedge rstAll) begin
        if (rstAll) begin
            port0Out <= `GPX_OUT_RST;
            port1Out <= `GPX_OUT_RST;
            inv0 <= `GPX_INV_RST;
            inv1 <= `GPX_INV_RST;
            port0OeN <= `GPX_DIR_RST;
            port1OeN <= `GPX_DIR_RST;
            sysRdata <= 8'h00;
            ackTog <= 1'b0;
            snap <= 16'h0000;
            initCnt <= 2'h0;
            intOeN <= 1'b1;
            intOut <= 1'b0;
        end else begin
            port0Out <= next_port0Out;
            port1Out <= next_port1Out;
            inv0 <= next_inv0;
            inv1 <= next_inv1;
            port0OeN <= next_port0OeN;
            port1OeN <= next_port1OeN;
            sysRdata <= next_sysRdata;
            ackTog <= next_ackTog;
            snap <= next_snap;
            initCnt <= next_initCnt;
            intOeN <= next_intOeN;
            intOut <= 1'b0;
        end
    end

    start_enter_a: assert property (
        @(posedge linkClk) disable iff (rstAll)
        (startSeen && !stopSeen)
        |=> (state == gpx_pkg::GPX_ADDR && bitCnt == 4'h0 && sdaOeN))
        else $error("start not taken");
    stop_idle_a: assert property (
        @(posedge linkClk) disable iff (rstAll)
        stopSeen |=> (state == gpx_pkg::GPX_IDLE && sdaOeN))
        else $error("stop did not idle");
    addr_ack_a: assert property (
        @(posedge linkClk) disable iff (rstAll)
        (state == gpx_pkg::GPX_ADDR && sclFall && bitCnt == `GPX_BITS
            && addrHit) |=> (!sdaOeN && state == gpx_pkg::GPX_ADDR_ACK))
        else $error("own address not acked");
    addr_miss_a: assert property (
        @(posedge linkClk) disable iff (rstAll)
        (state == gpx_pkg::GPX_ADDR && sclFall && bitCnt == `GPX_BITS
            && !addrHit) |=> (sdaOeN && state == gpx_pkg::GPX_IDLE))
        else $error("foreign address answered");
    rx_ack_a: assert property (
        @(posedge linkClk) disable iff (rstAll)
        (state == gpx_pkg::GPX_RX && sclFall && bitCnt == `GPX_BITS)
        |=> (!sdaOeN && state == gpx_pkg::GPX_RX_ACK))
        else $error("byte not acked");
    ack_hold_a: assert property (
        @(posedge linkClk) disable iff (rstAll)
        (state == gpx_pkg::GPX_RX_ACK && !sclFall && !stopSeen
            && !startSeen) |=> !sdaOeN)
        else $error("ack dropped early");
    tx_stable_a: assert property (
        @(posedge linkClk) disable iff (rstAll)
        (state == gpx_pkg::GPX_TX && sclRise) |=> $stable(sdaOeN))
        else $error("data moved at clock rise");
    nack_release_a: assert property (
        @(posedge linkClk) disable iff (rstAll)
        (state == gpx_pkg::GPX_TX_ACK && sclFall && !acked
            && !startSeen && !stopSeen)
        |=> (sdaOeN && state == gpx_pkg::GPX_IDLE))
        else $error("line held after nack");
    ptr_flip_a: assert property (
        @(posedge linkClk) disable iff (rstAll)
        (state == gpx_pkg::GPX_TX_ACK && sclRise)
        |=> (ptr[0] != $past(ptr[0]) && ptr[2:1] == $past(ptr[2:1])))
        else $error("pointer did not flip");
    input_ro_a: assert property (
        @(posedge clk_sys) disable iff (rstAll)
        (reqEvent && reqWr && isInputReg(reqIdx))
        |=> ($stable(port0Out) && $stable(port1Out) && $stable(inv0)
            && $stable(inv1) && $stable(port0OeN) && $stable(port1OeN)))
        else $error("input register write stored");
    level_read_a: assert property (
        @(posedge clk_sys) disable iff (rstAll)
        (reqEvent && !reqWr && reqIdx == `GPX_REG_IN1)
        |=> sysRdata == ($past(pinS[15:8]) ^ $past(inv1)))
        else $error("input read value wrong");
    int_raise_a: assert property (
        @(posedge clk_sys) disable iff (rstAll)
        pending |=> !intOeN)
        else $error("interrupt not raised");
    int_clear_a: assert property (
        @(posedge clk_sys) disable iff (rstAll)
        (reqEvent && reqClr && !reqClrPort)
        |=> snap[7:0] == $past(pinS[7:0]))
        else $error("read did not clear");

endmodule : gpx_expander

// *** pkg/gpx_cfg.svh ***
`ifndef GPX_CFG_SVH
`define GPX_CFG_SVH

// fixed upper six bits of the seven-bit slave address
`define GPX_ADDR_FIXED 6'h10
// data bits per byte, before the acknowledge slot
`define GPX_BITS 4'h8

// register indices carried by the command byte
`define GPX_REG_IN0 3'h0
`define GPX_REG_IN1 3'h1
`define GPX_REG_OUT0 3'h2
`define GPX_REG_OUT1 3'h3
`define GPX_REG_INV0 3'h4
`define GPX_REG_INV1 3'h5
`define GPX_REG_DIR0 3'h6
`define GPX_REG_DIR1 3'h7

// reset values
`define GPX_OUT_RST 8'hFF
`define GPX_INV_RST 8'h00
`define GPX_DIR_RST 8'hFF
`define GPX_PTR_RST 3'h0

// sys cycles after reset before the interrupt snapshot freezes
`define GPX_INIT_WAIT 2'h3

`endif

// *** pkg/gpx_pkg.sv ***
package gpx_pkg;

    // gray coded along idle, address, ack, receive / transmit
    typedef enum logic [2:0] {
        GPX_IDLE = 3'h0,
        GPX_ADDR = 3'h1,
        GPX_ADDR_ACK = 3'h3,
        GPX_RX = 3'h2,
        GPX_RX_ACK = 3'h6,
        GPX_TX = 3'h7,
        GPX_TX_ACK = 3'h5
    } gpx_state_t;

endpackage : gpx_pkg

// *** bench/gpx_master_model.sv ***
`timescale 1ns/100ps
module gpx_master_model (
    input wire logic clk_sys,
    input wire logic sdaWire,
    output logic scl,
    output logic sdaLow
);
    // clock rests high between frames
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end

    // 700 ns quarter bit leaves room for the link-side crossing
    task automatic q();
        repeat (7) @(posedge clk_sys);
        #1;
    endtask : q

    task automatic start();
        sdaLow = 1'b0;
        q();
        scl = 1'b1;
        q();
        sdaLow = 1'b1;
        q();
        scl = 1'b0;
        q();
    endtask : start

    task automatic bitIo(input logic b, output logic r);
        sdaLow = !b;
        q();
        scl = 1'b1;
        q();
        r = sdaWire;
        q();
        scl = 1'b0;
        q();
    endtask : bitIo

    task automatic xByte(input logic [7:0] d, input logic ackIn,
                         output logic [7:0] r, output logic ackOut);
        for (int i = 7; i >= 0; i--) bitIo(d[i], r[i]);
        bitIo(ackIn, ackOut);
    endtask : xByte

    task automatic stop();
        sdaLow = 1'b1;
        q();
        scl = 1'b1;
        q();
        sdaLow = 1'b0;
        q();
    endtask : stop
endmodule : gpx_master_model

// *** bench/i2c_16bit_gpio_expander_tb_top.sv ***
`timescale 1ns/100ps
`include "gpx_cfg.svh"
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module i2c_16bit_gpio_expander_tb_top;
    logic clk_sys = 1'b0;
    logic linkClk = 1'b0;
    logic reset = 1'b1;
    logic resetN = 1'b1;
    logic addrSel = 1'b0;
    logic [7:0] ext0 = 8'h5A;
    logic [7:0] ext1 = 8'hC3;
    logic scl, sdaLow, sdaOut, sdaOeN, intOut, intOeN, ack;
    logic [7:0] port0Out, port1Out, port0OeN, port1OeN, rd;
    int fails = 0;
    int checkCount = 0;
    // open-drain wire with pull-up; pins follow the driver when enabled
    wire logic sdaWire = !(sdaLow || (!sdaOeN && !sdaOut));
    wire logic [7:0] pin0 = (port0Out & ~port0OeN) | (ext0 & port0OeN);
    wire logic [7:0] pin1 = (port1Out & ~port1OeN) | (ext1 & port1OeN);
    wire logic [6:0] ownAddr = {`GPX_ADDR_FIXED, addrSel};

    always #50 clk_sys = !clk_sys;
    initial begin
        #1.3;
        forever #3 linkClk = !linkClk;
    end

    gpx_expander dut (.clk_sys(clk_sys), .reset(reset), .linkClk(linkClk),
        .resetN(resetN), .addrSel(addrSel), .sclIn(scl), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOeN(sdaOeN), .port0In(pin0), .port1In(pin1),
        .port0Out(port0Out), .port1Out(port1Out), .port0OeN(port0OeN),
        .port1OeN(port1OeN), .intOut(intOut), .intOeN(intOeN));
    gpx_master_model m (.clk_sys(clk_sys), .sdaWire(sdaWire), .scl(scl),
        .sdaLow(sdaLow));

    task automatic completeRun();
        $display("mismatches %0d of %0d compares", fails, checkCount);
        if (fails == 0 && checkCount > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : completeRun

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    // last address bit is the direction
    task automatic addr(input logic rw, input logic [6:0] a, input logic e);
        m.start();
        m.xByte({a, rw}, 1'b1, rd, ack);
        `CHK(ack, e)
    endtask : addr

    task automatic wrReg(input logic [7:0] c, d0, d1);
        addr(1'b0, ownAddr, 1'b0);
        m.xByte(c, 1'b1, rd, ack);
        `CHK(ack, 1'b0)
        m.xByte(d0, 1'b1, rd, ack);
        `CHK(ack, 1'b0)
        m.xByte(d1, 1'b1, rd, ack);
        `CHK(ack, 1'b0)
        m.stop();
    endtask : wrReg

    task automatic rdNext(input logic [7:0] e0, e1);
        addr(1'b1, ownAddr, 1'b0);
        m.xByte(8'hFF, 1'b0, rd, ack);
        `CHK(rd, e0)
        m.xByte(8'hFF, 1'b1, rd, ack);
        `CHK(rd, e1)
        `CHK(sdaOeN, 1'b1)
        m.stop();
    endtask : rdNext

    task automatic rdPair(input logic [7:0] c, e0, e1);
        addr(1'b0, ownAddr, 1'b0);
        m.xByte(c, 1'b1, rd, ack);
        rdNext(e0, e1);
    endtask : rdPair

    task automatic waitInt(input logic e);
        int n;
        n = 0;
        while (intOeN !== e && n < 20) begin
            tick(1);
            n++;
        end
        `CHK({intOut, intOeN}, {1'b0, e})
        if (intOeN !== e) completeRun();
    endtask : waitInt

    initial begin
        tick(6);
        reset = 1'b0;
        tick(4);
        rdPair(8'h02, `GPX_OUT_RST, `GPX_OUT_RST);
        rdPair(8'h05, `GPX_INV_RST, `GPX_INV_RST);
        rdPair(8'h07, `GPX_DIR_RST, `GPX_DIR_RST);
        rdPair(8'h01, 8'hC3, 8'h5A);
        wrReg(8'h04, 8'h0F, 8'hF0);
        rdPair(8'h00, 8'h55, 8'h33);
        rdNext(8'h55, 8'h33);
        wrReg(8'h00, 8'h00, 8'h00);
        rdPair(8'h00, 8'h55, 8'h33);
        rdPair(8'h04, 8'h0F, 8'hF0);
        wrReg(8'h03, 8'h3C, 8'hA5);
        `CHK({port1Out, port0Out}, 16'h3CA5)
        `CHK(port0OeN, 8'hFF)
        wrReg(8'h06, 8'h0F, 8'hF0);
        `CHK({port1OeN, port0OeN}, 16'hF00F)
        rdPair(8'h02, 8'hA5, 8'h3C);
        rdPair(8'h00, 8'hA5, 8'h3C);
        waitInt(1'b1);
        // port 0 bit 7 is an output now, so its far side must stay quiet
        ext0[7] = !ext0[7];
        tick(20);
        `CHK(intOeN, 1'b1)
        ext1[7] = !ext1[7];
        waitInt(1'b0);
        ext1[7] = !ext1[7];
        waitInt(1'b1);
        ext1[7] = !ext1[7];
        waitInt(1'b0);
        rdPair(8'h01, 8'hBC, 8'hA5);
        waitInt(1'b1);
        addr(1'b0, 7'h22, 1'b1);
        m.stop();
        addrSel = 1'b1;
        addr(1'b1, 7'h20, 1'b1);
        m.stop();
        rdNext(8'hBC, 8'hA5);
        resetN = 1'b0;
        tick(2);
        resetN = 1'b1;
        `CHK({port1OeN, port0OeN, port1Out, port0Out}, 32'hFFFFFFFF)
        tick(4);
        rdPair(8'h06, `GPX_DIR_RST, `GPX_DIR_RST);
        completeRun();
    end
endmodule : i2c_16bit_gpio_expander_tb_top
